// file: scsw_pkg.sv
// constants and carrier types for the system control, status and watchdog block
package scsw_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned WD_MIN_PERIOD_MS = 10;
   localparam int unsigned WD_BASE_CYCLES = WD_MIN_PERIOD_MS * (CLK_HZ / 1000);
   localparam int unsigned LIN_CL_OFF_US = 500;
   localparam int unsigned LIN_CL_OFF_CYCLES = LIN_CL_OFF_US * (CLK_HZ / 1_000_000);
   localparam int unsigned WD_CNT_W = 24;
   localparam int unsigned LIN_CNT_W = 17;

   // register addresses on the spi link
   localparam logic [4:0] ADDR_SYSTEM_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_HIGH_SIDE_STATUS = 5'h04;
   localparam logic [4:0] ADDR_WATCHDOG_CONTROL = 5'h0b;
   localparam logic [4:0] ADDR_SYSTEM_STATUS = 5'h0c;
   localparam logic [7:0] REG_RESET = 8'h00;

   // field positions
   localparam int unsigned SC_STOP_BIT = 6;
   localparam int unsigned SC_SLEEP_BIT = 5;
   localparam logic [7:0] SC_STOP_GUARD = 8'hbc;
   localparam logic [7:0] SC_SLEEP_GUARD = 8'hdc;
   localparam int unsigned HS_5V_OCF_BIT = 7;
   localparam int unsigned WD_ENABLE_BIT = 7;
   localparam int unsigned WD_RESTART_BIT = 3;

   // spi frame
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] PARITY_SAMPLE = 5'h06;
   localparam int unsigned PIN_SS = 2;
   localparam int unsigned PIN_SCK = 1;
   localparam int unsigned PIN_MOSI = 0;
   localparam logic [2:0] PIN_IDLE = 3'h4;

   typedef struct packed {
      logic power_stage_enable;
      logic stop;
      logic sleep;
      logic low_side_thermal_shutdown_select;
      logic high_side_thermal_shutdown_select;
      logic voltage_shutdown_select;
      logic [1:0] srs;
   } system_control_t;

   typedef struct packed {
      logic lin_cl;
      logic htf;
      logic vf;
      logic h0f;
      logic s5vf;
      logic high_side_failure_summary;
      logic half_bridge_failure_summary;
      logic zero;
   } status_t;

   typedef struct packed {
      logic [2:0] high_side;
      logic half_bridge_high;
      logic half_bridge_low;
      logic lin_tx;
      logic a0_source;
      logic switched_5v;
   } power_en_t;

   typedef enum logic [1:0] {
      SLEW_INITIAL_20K,
      SLEW_HIGH_8X,
      SLEW_SLOW_10K,
      SLEW_HIGH_4X
   } lin_slew_t;

endpackage : scsw_pkg

// file: system_control_status_watchdog.sv
// system control, status, over-current flags and window watchdog behind the spi link
//
// Summary of operation
// RQ1 - high side over-current flags set, write-one clears
// RQ2 - switched 5V over-current flag, write-one clears
// RQ3 - power stage enable gates all power outputs
// RQ4 - stop request enters stop, irq clears
// RQ5 - stop only when other control bits except slew select are zero
// RQ6 - sleep only when other bits except slew select zero, irq clears
// RQ7 - high side thermal shutdown select
// RQ8 - low side thermal shutdown select
// RQ9 - voltage failure disables power stages except switched 5V, unless voltage shutdown select is set
// RQ10 - two-bit LIN slew select decode
// RQ11 - LIN current limit status, timed transmitter off
// RQ12 - status mirrors high temperature flag
// RQ13 - voltage failure is low OR high
// RQ14 - status mirrors auxiliary high side over-current
// RQ15 - status mirrors switched 5V over-current flag
// RQ16 - high side and half-bridge failure summaries
// RQ17 - watchdog enable set once, reset clears
// RQ18 - restart clears counter at frame end
// RQ19 - watchdog bites at end or early restart
// RQ20 - watchdog period select 80/40/20/10 ms
// RQ21 - stop halts watchdog, wake clears timer
// RQ22 - sleep entry halts watchdog, clears enable
// RQ23 - writes at slave-select rise, sixteen samples only
// RQ24 - closed first half, open second half
// RQ25 - restart, stop, sleep bits read zero
`timescale 1ns/1ps
`default_nettype none

module system_control_status_watchdog #(
   parameter int unsigned WD_BASE_CYCLES = scsw_pkg::WD_BASE_CYCLES,
   parameter int unsigned LIN_CL_OFF_CYCLES = scsw_pkg::LIN_CL_OFF_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // spi link, this die is slave
   input wire logic spi_ss_n_in,
   input wire logic spi_sck_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_n_out,
   // analog status
   input wire logic [2:0] hs_overcurrent_in,
   input wire logic switched_5v_overcurrent_in,
   input wire logic [3:0] half_bridge_overcurrent_in,
   input wire logic aux_high_side_overcurrent_flag_in,
   input wire logic lin_current_limit_in,
   input wire logic high_temperature_flag_in,
   input wire logic low_voltage_flag_in,
   input wire logic high_voltage_flag_in,
   input wire logic cpu_irq_in,
   // control outputs
   output var scsw_pkg::power_en_t power_enable_out,
   output var scsw_pkg::lin_slew_t lin_slew_mode_out,
   output logic stop_mode_out,
   output logic sleep_mode_out,
   output logic watchdog_reset_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a change counts once stages two and three agree
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [2:0] pin_filt_q;
   logic [2:0] pin_filt_d;
   logic [2:0] pin_prev_q;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pin_s1_q <= scsw_pkg::PIN_IDLE;
         pin_s2_q <= scsw_pkg::PIN_IDLE;
         pin_s3_q <= scsw_pkg::PIN_IDLE;
         pin_filt_q <= scsw_pkg::PIN_IDLE;
         pin_prev_q <= scsw_pkg::PIN_IDLE;
      end else begin
         pin_s1_q <= {spi_ss_n_in, spi_sck_in, spi_mosi_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_filt_q <= pin_filt_d;
         pin_prev_q <= pin_filt_q;
      end
   end

   assign pin_filt_d = ((pin_s2_q ~^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_filt_q);

   logic ss_active;
   logic ss_fall;
   logic ss_rise;
   logic sck_rise;
   logic sck_fall;
   logic mosi_bit;

   assign ss_active = ~pin_filt_q[scsw_pkg::PIN_SS];
   assign ss_fall = pin_prev_q[scsw_pkg::PIN_SS] & ~pin_filt_q[scsw_pkg::PIN_SS];
   assign ss_rise = ~pin_prev_q[scsw_pkg::PIN_SS] & pin_filt_q[scsw_pkg::PIN_SS];
   assign sck_rise = ss_active & ~pin_prev_q[scsw_pkg::PIN_SCK] & pin_filt_q[scsw_pkg::PIN_SCK];
   assign sck_fall = ss_active & pin_prev_q[scsw_pkg::PIN_SCK] & ~pin_filt_q[scsw_pkg::PIN_SCK];
   assign mosi_bit = pin_filt_q[scsw_pkg::PIN_MOSI];

   ////////////////////////////////////////////////////////////////////////////
   // spi frame: address, r/w, parity, spare, then data byte, msb first
   logic [4:0] bit_cnt_q;
   logic [15:0] rx_q;
   logic [15:0] rx_next;
   logic [15:0] tx_q;
   logic miso_oe_n_q;

   assign rx_next = {rx_q[14:0], mosi_bit};

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         bit_cnt_q <= 5'h00;
         rx_q <= 16'h0000;
      end else if (ss_fall) begin
         bit_cnt_q <= 5'h00;
         rx_q <= 16'h0000;
      end else if (sck_fall) begin
         rx_q <= rx_next;
         if (bit_cnt_q != 5'h1f) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   logic frame_ok;
   logic [4:0] frame_addr;
   logic [7:0] frame_data;
   logic frame_write;

   // parity is even over r/w, address and parity bit
   assign frame_ok = ss_rise && (bit_cnt_q == scsw_pkg::FRAME_BITS); // RQ23
   assign frame_addr = rx_q[15:11];
   assign frame_data = rx_q[7:0];
   assign frame_write = frame_ok && !rx_q[10] && !(^rx_q[15:9]); // RQ23

   logic sc_wr;
   logic hs_wr;
   logic wd_wr;

   always_comb begin
      sc_wr = 1'b0;
      hs_wr = 1'b0;
      wd_wr = 1'b0;
      if (frame_write && frame_addr == scsw_pkg::ADDR_SYSTEM_CONTROL) begin
         sc_wr = 1'b1;
      end else if (frame_write && frame_addr == scsw_pkg::ADDR_HIGH_SIDE_STATUS) begin
         hs_wr = 1'b1;
      end else if (frame_write && frame_addr == scsw_pkg::ADDR_WATCHDOG_CONTROL) begin
         wd_wr = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   scsw_pkg::system_control_t system_control_q;
   scsw_pkg::status_t status_q;
   logic [2:0] hs_ocf_q;
   logic s5v_ocf_q;
   logic watchdog_enable_q;
   logic [1:0] wdp_q;
   logic stop_q;
   logic sleep_q;
   logic stop_set;
   logic sleep_set;

   assign stop_set = sc_wr && frame_data[scsw_pkg::SC_STOP_BIT]
      && ((frame_data & scsw_pkg::SC_STOP_GUARD) == scsw_pkg::REG_RESET); // RQ5
   assign sleep_set = sc_wr && frame_data[scsw_pkg::SC_SLEEP_BIT]
      && ((frame_data & scsw_pkg::SC_SLEEP_GUARD) == scsw_pkg::REG_RESET); // RQ6

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         system_control_q <= scsw_pkg::system_control_t'(scsw_pkg::REG_RESET);
      end else if (sc_wr) begin
         system_control_q <= scsw_pkg::system_control_t'(frame_data);
         system_control_q.stop <= 1'b0; // RQ25
         system_control_q.sleep <= 1'b0; // RQ25
      end
   end

   // mode requests: a set in the same cycle as an irq wins
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         stop_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         stop_q <= stop_set | (stop_q & ~cpu_irq_in); // RQ4
         sleep_q <= sleep_set | (sleep_q & ~cpu_irq_in); // RQ6
      end
   end

   logic [2:0] hs_clr;
   logic s5v_clr;

   assign hs_clr = hs_wr ? frame_data[2:0] : 3'h0;
   assign s5v_clr = hs_wr & frame_data[scsw_pkg::HS_5V_OCF_BIT];

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         hs_ocf_q <= 3'h0;
         s5v_ocf_q <= 1'b0;
      end else begin
         hs_ocf_q <= (hs_ocf_q & ~hs_clr) | hs_overcurrent_in; // RQ1
         s5v_ocf_q <= (s5v_ocf_q & ~s5v_clr) | switched_5v_overcurrent_in; // RQ2
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         watchdog_enable_q <= 1'b0;
         wdp_q <= 2'h0;
      end else begin
         if (sleep_set) begin
            watchdog_enable_q <= 1'b0; // RQ22
         end else if (wd_wr && frame_data[scsw_pkg::WD_ENABLE_BIT]) begin
            watchdog_enable_q <= 1'b1; // RQ17
         end
         if (wd_wr) begin
            wdp_q <= frame_data[1:0]; // RQ20
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         status_q <= scsw_pkg::status_t'(scsw_pkg::REG_RESET);
      end else begin
         status_q.lin_cl <= lin_current_limit_in; // RQ11
         status_q.htf <= high_temperature_flag_in; // RQ12
         status_q.vf <= low_voltage_flag_in | high_voltage_flag_in; // RQ13
         status_q.h0f <= aux_high_side_overcurrent_flag_in; // RQ14
         status_q.s5vf <= s5v_ocf_q; // RQ15
         status_q.high_side_failure_summary <= |hs_ocf_q; // RQ16
         status_q.half_bridge_failure_summary <= |half_bridge_overcurrent_in; // RQ16
         status_q.zero <= 1'b0;
      end
   end

   function automatic logic [7:0] read_reg(input logic [4:0] addr);
      logic [7:0] val;
      val = scsw_pkg::REG_RESET;
      if (addr == scsw_pkg::ADDR_SYSTEM_CONTROL) begin
         val = system_control_q; // RQ25
      end else if (addr == scsw_pkg::ADDR_HIGH_SIDE_STATUS) begin
         val[scsw_pkg::HS_5V_OCF_BIT] = s5v_ocf_q;
         val[2:0] = hs_ocf_q;
      end else if (addr == scsw_pkg::ADDR_WATCHDOG_CONTROL) begin
         val[scsw_pkg::WD_ENABLE_BIT] = watchdog_enable_q;
         val[1:0] = wdp_q; // RQ25
      end else if (addr == scsw_pkg::ADDR_SYSTEM_STATUS) begin
         val = status_q;
      end
      return val;
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////////////////
   // miso: status byte from frame start, register data caught at parity bit
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         tx_q <= 16'h0000;
      end else if (ss_fall) begin
         tx_q <= {status_q, scsw_pkg::REG_RESET};
      end else if (sck_fall && bit_cnt_q == scsw_pkg::PARITY_SAMPLE) begin
         // six shifts have passed, so the data byte lands where shift eight exposes it
         tx_q[13:6] <= read_reg(rx_next[6:2]);
      end else if (sck_rise && bit_cnt_q != 5'h00) begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         miso_oe_n_q <= 1'b1;
      end else begin
         miso_oe_n_q <= pin_filt_d[scsw_pkg::PIN_SS];
      end
   end

   assign spi_miso_out = tx_q[15];
   assign spi_miso_oe_n_out = miso_oe_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // window watchdog
   logic [scsw_pkg::WD_CNT_W-1:0] wd_cnt_q;
   logic [scsw_pkg::WD_CNT_W-1:0] wd_period;
   logic wd_run;
   logic wd_restart;
   logic wd_closed;
   logic wd_bite;
   logic wd_reset_q;

   always_comb begin
      case (wdp_q) // RQ20
         2'h0: wd_period = scsw_pkg::WD_CNT_W'(WD_BASE_CYCLES * 8);
         2'h1: wd_period = scsw_pkg::WD_CNT_W'(WD_BASE_CYCLES * 4);
         2'h2: wd_period = scsw_pkg::WD_CNT_W'(WD_BASE_CYCLES * 2);
         default: wd_period = scsw_pkg::WD_CNT_W'(WD_BASE_CYCLES);
      endcase
   end

   assign wd_run = watchdog_enable_q & ~stop_q & ~sleep_q; // RQ17
   assign wd_restart = wd_wr & frame_data[scsw_pkg::WD_RESTART_BIT]; // RQ18
   assign wd_closed = wd_cnt_q < (wd_period >> 1); // RQ24
   assign wd_bite = wd_run && ((wd_cnt_q >= wd_period - 1'b1) || (wd_restart && wd_closed)); // RQ19

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         wd_cnt_q <= '0;
      end else if (!wd_run || wd_bite || wd_restart) begin
         wd_cnt_q <= '0; // RQ21
      end else begin
         wd_cnt_q <= wd_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         wd_reset_q <= 1'b0;
      end else begin
         wd_reset_q <= wd_bite; // RQ19
      end
   end

   assign watchdog_reset_out = wd_reset_q;

   ////////////////////////////////////////////////////////////////////////////
   // lin transmitter self shutdown after sustained current limitation
   logic [scsw_pkg::LIN_CNT_W-1:0] lin_cnt_q;
   logic lin_off_q;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         lin_cnt_q <= '0;
         lin_off_q <= 1'b0;
      end else begin
         if (!lin_current_limit_in) begin
            lin_cnt_q <= '0;
         end else if (lin_cnt_q != scsw_pkg::LIN_CNT_W'(LIN_CL_OFF_CYCLES - 1)) begin
            lin_cnt_q <= lin_cnt_q + 1'b1;
         end
         if (!system_control_q.power_stage_enable) begin
            lin_off_q <= 1'b0;
         end else if (lin_cnt_q == scsw_pkg::LIN_CNT_W'(LIN_CL_OFF_CYCLES - 1)) begin
            lin_off_q <= 1'b1; // RQ11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power stage enables and mode outputs
   logic temp_hi_off;
   logic temp_lo_off;
   logic volt_off;
   scsw_pkg::power_en_t power_q;
   scsw_pkg::lin_slew_t slew_q;

   assign temp_hi_off = high_temperature_flag_in & ~system_control_q.high_side_thermal_shutdown_select; // RQ7
   assign temp_lo_off = high_temperature_flag_in & ~system_control_q.low_side_thermal_shutdown_select; // RQ8
   assign volt_off = (low_voltage_flag_in | high_voltage_flag_in) & ~system_control_q.voltage_shutdown_select; // RQ9

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         power_q <= '0;
      end else begin
         power_q.high_side <= {3{system_control_q.power_stage_enable & ~temp_hi_off & ~volt_off}} & ~hs_ocf_q; // RQ3
         power_q.half_bridge_high <= system_control_q.power_stage_enable & ~temp_hi_off & ~volt_off; // RQ7
         power_q.half_bridge_low <= system_control_q.power_stage_enable & ~temp_lo_off & ~volt_off; // RQ8
         power_q.lin_tx <= system_control_q.power_stage_enable & ~lin_off_q & ~volt_off; // RQ3
         power_q.a0_source <= system_control_q.power_stage_enable & ~volt_off; // RQ3
         power_q.switched_5v <= system_control_q.power_stage_enable & ~s5v_ocf_q; // RQ2
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         slew_q <= scsw_pkg::SLEW_INITIAL_20K;
      end else begin
         case (system_control_q.srs) // RQ10
            2'h0: slew_q <= scsw_pkg::SLEW_INITIAL_20K;
            2'h1: slew_q <= scsw_pkg::SLEW_HIGH_8X;
            2'h2: slew_q <= scsw_pkg::SLEW_SLOW_10K;
            default: slew_q <= scsw_pkg::SLEW_HIGH_4X;
         endcase
      end
   end

   assign power_enable_out = power_q;
   assign lin_slew_mode_out = slew_q;
   assign stop_mode_out = stop_q;
   assign sleep_mode_out = sleep_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);

   AST_HS_OCF_SET: assert property (hs_overcurrent_in[0] |=> hs_ocf_q[0]) // RQ1
      else $error("high side flag not set by over-current");
   AST_S5V_OCF_HOLD: assert property (s5v_ocf_q && !s5v_clr |=> s5v_ocf_q) // RQ2
      else $error("switched 5V flag lost without clear");
   AST_POWER_STAGE_ENABLE_OFF: assert property (!system_control_q.power_stage_enable |=> power_q == '0) // RQ3
      else $error("power stage on while enable is low");
   AST_STOP_GUARD: assert property (sc_wr && !stop_q
      && (frame_data & scsw_pkg::SC_STOP_GUARD) != scsw_pkg::REG_RESET |=> !stop_q) // RQ5
      else $error("stop entered with other bits set");
   AST_VF_OR: assert property (##1 status_q.vf == $past(low_voltage_flag_in | high_voltage_flag_in)) // RQ13
      else $error("voltage failure not the or of flags");
   AST_WATCHDOG_ENABLE_STICKY: assert property (watchdog_enable_q && !sleep_set |=> watchdog_enable_q) // RQ17
      else $error("watchdog enable cleared by software");
   AST_WD_END_BITE: assert property (wd_run && wd_cnt_q == wd_period - 1'b1 |=> watchdog_reset_out) // RQ19
      else $error("watchdog did not bite at end value");
   AST_WD_CLOSED_BITE: assert property (wd_run && wd_restart
      && wd_cnt_q < (wd_period >> 1) |=> watchdog_reset_out) // RQ24
      else $error("restart in closed window not punished");
   AST_WD_STOP_HALT: assert property (stop_q |=> wd_cnt_q == '0 && !watchdog_reset_out) // RQ21
      else $error("watchdog counting in stop mode");
   AST_WRITE_AT_FRAME_END: assert property ($changed(system_control_q) |-> $past(ss_rise)) // RQ23
      else $error("control register changed outside frame end");

   COV_WD_BITE: cover property (watchdog_reset_out);
   COV_STOP_ENTRY: cover property ($rose(stop_q));
   COV_SLEEP_ENTRY: cover property ($rose(sleep_q) ##[1:20] !sleep_q);
   COV_HS_CLEAR: cover property (hs_ocf_q[0] ##1 !hs_ocf_q[0]);

endmodule : system_control_status_watchdog

`default_nettype wire

// file: spi_mcu_model.sv
// spi master model standing in for the embedded microcontroller
`timescale 1ns/1ps
`default_nettype none

module spi_mcu_model #(
   parameter int HALF = 4
) (
   // clock
   input wire logic clk_in,
   // spi pins
   input wire logic miso_in,
   output logic ss_n_out,
   output logic sck_out,
   output logic mosi_out
);

   // idle levels follow the pull-up on select and pull-downs on clock and data
   initial begin
      ss_n_out = 1'b1;
      sck_out = 1'b0;
      mosi_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   // one frame of nbits clocks, msb first; miso stands until the next sck rise
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      tick(1);
      ss_n_out = 1'b0;
      tick(HALF + 1);
      for (int i = 0; i < nbits; i++) begin
         mosi_out = word[15 - i];
         sck_out = 1'b1;
         tick(HALF);
         sck_out = 1'b0;
         tick(HALF);
         rx[15 - i] = miso_in;
      end
      mosi_out = 1'b0;
      ss_n_out = 1'b1;
      tick(10);
   endtask : xfer

endmodule : spi_mcu_model
`default_nettype wire

// file: system_control_status_watchdog_tb_top.sv
// self-checking bench: spi register traffic, status, flags and watchdog
`timescale 1ns/1ps
`default_nettype none

module system_control_status_watchdog_tb_top;
   localparam logic [4:0] A_SC = scsw_pkg::ADDR_SYSTEM_CONTROL;
   localparam logic [4:0] A_HS = scsw_pkg::ADDR_HIGH_SIDE_STATUS;
   localparam logic [4:0] A_WD = scsw_pkg::ADDR_WATCHDOG_CONTROL;
   localparam logic [4:0] A_ST = scsw_pkg::ADDR_SYSTEM_STATUS;
   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic ss_n, sck, mosi, miso_out, miso_oe_n, miso_pin, stop_m, sleep_m, wd_bite;
   logic [2:0] hs_oc = 3'h0;
   logic [3:0] hb_oc = 4'h0;
   logic s5v_oc = 1'b0, aux_oc = 1'b0, lin_cl = 1'b0, htf = 1'b0;
   logic low_v = 1'b0, high_v = 1'b0, irq = 1'b0;
   scsw_pkg::power_en_t pwr_en;
   scsw_pkg::lin_slew_t slew;
   int num_errors = 0, checks = 0, bites = 0;
   integer seed = 32'hd315_50fc;
   logic [2:0] hs_flag_m = 3'h0;
   logic s5v_flag_m = 1'b0;
   logic [7:0] sc_m = 8'h00, d, r;
   logic [7:0] tab_sc [5] = '{8'h80, 8'h88, 8'h90, 8'h80, 8'h84};
   logic [1:0] tab_in [5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
   logic [7:0] tab_pe [5] = '{8'h07, 8'hf7, 8'h0f, 8'h01, 8'hff};
   logic [7:0] tab_ss [4] = '{8'h44, 8'h24, 8'h40, 8'h20};
   logic [7:0] tab_hs [4] = '{8'h01, 8'h00, 8'h80, 8'h07};

   assign miso_pin = miso_oe_n ? 1'bz : miso_out;

   system_control_status_watchdog #(.WD_BASE_CYCLES(200), .LIN_CL_OFF_CYCLES(20)) dut_u (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .spi_ss_n_in(ss_n), .spi_sck_in(sck),
      .spi_mosi_in(mosi), .spi_miso_out(miso_out), .spi_miso_oe_n_out(miso_oe_n),
      .hs_overcurrent_in(hs_oc), .switched_5v_overcurrent_in(s5v_oc),
      .half_bridge_overcurrent_in(hb_oc), .aux_high_side_overcurrent_flag_in(aux_oc),
      .lin_current_limit_in(lin_cl), .high_temperature_flag_in(htf),
      .low_voltage_flag_in(low_v), .high_voltage_flag_in(high_v), .cpu_irq_in(irq),
      .power_enable_out(pwr_en), .lin_slew_mode_out(slew), .stop_mode_out(stop_m),
      .sleep_mode_out(sleep_m), .watchdog_reset_out(wd_bite)
   );

   spi_mcu_model #(.HALF(4)) mdl_u (
      .clk_in(sys_clk_in), .miso_in(miso_pin), .ss_n_out(ss_n), .sck_out(sck), .mosi_out(mosi)
   );

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   always @(posedge sys_clk_in) begin
      if (wd_bite === 1'b1) bites <= bites + 1;
   end

   function automatic logic [7:0] exp_status();
      return {lin_cl, htf, low_v | high_v, aux_oc, s5v_flag_m, |hs_flag_m, |hb_oc, 1'b0};
   endfunction : exp_status

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : tick

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (num_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // full frames check the status byte and the pre-write register byte
   task automatic frame(input logic [4:0] a, input logic rd, input logic [7:0] wd,
         input logic [7:0] exp_d, input int nbits, input logic bad_par);
      logic [15:0] rx;
      logic [7:0] es;
      es = exp_status();
      mdl_u.xfer({a, rd, ^{a, rd} ^ bad_par, 1'b0, wd}, nbits, rx);
      if (nbits == 16) begin
         check(rx[15:8], es);
         check(rx[7:0], exp_d);
      end
   endtask : frame

   task automatic pulse_irq();
      irq = 1'b1;
      tick(1);
      irq = 1'b0;
      tick(3);
   endtask : pulse_irq

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(20000);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      tick(10);
      srst_in = 1'b0;
      tick(4);
      check(pwr_en, 8'h00);
      check({7'h00, miso_oe_n}, 8'h01);
      frame(A_SC, 1'b1, 8'h00, 8'h00, 16, 1'b0);
      frame(A_HS, 1'b1, 8'h00, 8'h00, 16, 1'b0);
      frame(A_WD, 1'b1, 8'h00, 8'h00, 16, 1'b0);
      frame(5'h1f, 1'b0, 8'hff, 8'h00, 16, 1'b0);
      frame(5'h1f, 1'b1, 8'h00, 8'h00, 16, 1'b0);
      for (int s = 0; s < 4; s++) begin
         frame(A_SC, 1'b0, {6'h20, s[1:0]}, sc_m, 16, 1'b0);
         sc_m = {6'h20, s[1:0]};
         check({6'h00, slew}, {6'h00, s[1:0]});
      end
      check(pwr_en, 8'hff);
      for (int k = 0; k < 5; k++) begin
         {htf, low_v} = tab_in[k];
         tick(3);
         frame(A_SC, 1'b0, tab_sc[k], sc_m, 16, 1'b0);
         sc_m = tab_sc[k];
         check(pwr_en, tab_pe[k]);
      end
      {htf, low_v} = 2'h0;
      frame(A_SC, 1'b0, 8'h80, sc_m, 16, 1'b0);
      sc_m = 8'h80;
      lin_cl = 1'b1;
      tick(5);
      check({7'h00, pwr_en.lin_tx}, 8'h01);
      tick(30);
      check({7'h00, pwr_en.lin_tx}, 8'h00);
      lin_cl = 1'b0;
      tick(3);
      frame(A_SC, 1'b0, 8'h83, sc_m, 15, 1'b0);
      frame(A_SC, 1'b0, 8'h83, sc_m, 16, 1'b1);
      for (int k = 0; k < 4; k++) begin
         d = tab_ss[k];
         frame(A_SC, 1'b0, d, sc_m, 16, 1'b0);
         sc_m = d & 8'h9f;
         check({6'h00, stop_m, sleep_m},
               {6'h00, d[6] && !(d & 8'hbc), d[5] && !(d & 8'hdc)});
         pulse_irq();
         check({6'h00, stop_m, sleep_m}, 8'h00);
      end
      frame(A_SC, 1'b0, 8'h80, sc_m, 16, 1'b0);
      sc_m = 8'h80;
      r = 8'($random(seed));
      hs_flag_m = r[2:0] | 3'h1;
      s5v_flag_m = 1'b1;
      hs_oc = hs_flag_m;
      s5v_oc = 1'b1;
      tick(2);
      hs_oc = 3'h0;
      s5v_oc = 1'b0;
      tick(2);
      check({pwr_en.high_side, 4'h0, pwr_en.switched_5v},
            {~hs_flag_m, 4'h0, ~s5v_flag_m});
      for (int k = 0; k < 4; k++) begin
         frame(A_HS, 1'b0, tab_hs[k], {s5v_flag_m, 4'h0, hs_flag_m}, 16, 1'b0);
         hs_flag_m = hs_flag_m & ~tab_hs[k][2:0];
         s5v_flag_m = s5v_flag_m & ~tab_hs[k][7];
      end
      frame(A_HS, 1'b1, 8'h00, 8'h00, 16, 1'b0);
      check(pwr_en, 8'hff);
      repeat (6) begin
         r = 8'($random(seed));
         {lin_cl, htf, low_v, high_v, aux_oc} = r[4:0];
         hb_oc = r[7:4];
         tick(3);
         frame(A_ST, 1'b1, r, exp_status(), 16, 1'b0);
      end
      {lin_cl, htf, low_v, high_v, aux_oc, hb_oc} = 9'h000;
      tick(3);
      frame(A_WD, 1'b0, 8'h82, 8'h00, 16, 1'b0);
      frame(A_WD, 1'b0, 8'h8a, 8'h82, 16, 1'b0);
      check(8'(bites), 8'h01);
      frame(A_WD, 1'b0, 8'h02, 8'h82, 16, 1'b0);
      frame(A_WD, 1'b0, 8'h8a, 8'h82, 16, 1'b0);
      frame(A_WD, 1'b1, 8'h00, 8'h82, 16, 1'b0);
      tick(230);
      check(8'(bites), 8'h01);
      tick(40);
      check(8'(bites), 8'h02);
      frame(A_SC, 1'b0, 8'h40, sc_m, 16, 1'b0);
      sc_m = 8'h00;
      tick(600);
      check(8'(bites), 8'h02);
      pulse_irq();
      tick(370);
      check(8'(bites), 8'h02);
      tick(40);
      check(8'(bites), 8'h03);
      frame(A_SC, 1'b0, 8'h20, sc_m, 16, 1'b0);
      frame(A_WD, 1'b1, 8'h00, 8'h02, 16, 1'b0);
      pulse_irq();
      tick(500);
      check(8'(bites), 8'h03);
      tally_and_finish();
   end

endmodule : system_control_status_watchdog_tb_top
`default_nettype wire
